// ===== core/edoc_ctrl.sv
// page-mode dram host controller: init, accesses, page bursts and counter refresh
// What this block does
// - eighteen-bit address sent as row then column
// - cycle starts row low, ends all strobes high
// - keep row active and precharge minimums
// - write data driven on the same clock edge as the first falling column strobe
// - refresh all 512 rows every 8 ms
// - hold a column strobe for counter refresh
// - wait 200 us then eight row cycles
`timescale 1ns/100ps
module edoc_ctrl
    import edoc_pkg::*;
#(
    parameter int unsigned REF_PERIOD = REF_PERIOD_DEF,  // cycles between refreshes
    parameter int unsigned PWRUP_WAIT = PWRUP_DEF        // power-up pause in cycles
)(
    input  wire logic                   sys_clk_i,                 // system clock
    input  wire logic                   rst_n_i,                   // async reset, low
    input  wire logic                   req_valid_i,               // access request
    input  wire logic                   req_write_i,               // 1 write, 0 read
    input  wire logic                   req_last_i,                // close row after this
    input  wire logic [CELL_ADDR_W-1:0] req_addr_i,                // row high, column low
    input  wire logic [1:0]             req_lanes_i,               // byte lanes {hi,lo}
    input  wire logic [DATA_W-1:0]      req_wdata_i,               // write data
    output logic                        req_ready_o,               // request taken
    output logic                        rd_valid_o,                // read data pulse
    output logic [DATA_W-1:0]           rd_data_o,                 // read data
    output logic                        init_done_o,               // init finished
    output logic [ADDR_W-1:0]           muxed_address_o,           // muxed address
    output logic                        row_strobe_n_o,            // row strobe
    output logic                        low_lane_column_strobe_n_o,   // low lane strobe
    output logic                        high_lane_column_strobe_n_o,  // high lane strobe
    output logic                        write_enable_n_o,          // write enable
    output logic                        output_enable_n_o,         // output enable
    output logic [DATA_W-1:0]           data_lines_o,              // data out
    output logic                        data_lines_oe_n_o,         // low while driving
    input  wire logic [DATA_W-1:0]      data_lines_i               // data in
);
    import edoc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        edoc_state_t         fsm;
        logic [ADDR_W-1:0]   open_row;
        logic                row_open;
        logic                wr;
        logic [1:0]          lanes;
        logic                last;
        logic [DATA_W-1:0]   wdata;
        logic [3:0]          init_cnt;
        logic                init_done;
        logic                ref_pend;
        logic [TMR_W-1:0]    ref_tmr;
        logic [ADDR_W-1:0]   addr;
        logic                ras_n;
        logic [1:0]          cas_n;
        logic                we_n;
        logic                oe_n;
        logic [DATA_W-1:0]   dq;
        logic                dq_oe_n;
        logic                ready;
        logic                rvalid;
        logic [DATA_W-1:0]   rdata;
    } edoc_st_t;

    edoc_st_t          st;
    edoc_st_t          next_st;
    logic [1:0]        rst_sync;
    logic              rst_n;
    logic [DATA_W-1:0] dq_m;
    logic [DATA_W-1:0] dq_s;
    logic              tmr_load;
    logic [TMR_W-1:0]  tmr_count;
    logic              tmr_done;
    logic              ras_done;
    logic              pw_loaded;

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // read data is a pin input: two flops before use
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dq_m <= 16'h0;
            dq_s <= 16'h0;
        end
        else
        begin
            dq_m <= data_lines_i;
            dq_s <= dq_m;
        end
    end

    edoc_timer u_timer (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n),
        .load_i    (tmr_load),
        .count_i   (tmr_count),
        .done_o    (tmr_done)
    );

    // separate row-active timer so a page burst never closes early
    logic [3:0] ras_cnt;
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ras_cnt <= 4'h0;
        end
        else if (st.ras_n)
        begin
            ras_cnt <= 4'(RAS_CYC);
        end
        else if (ras_cnt != 4'h0)
        begin
            ras_cnt <= ras_cnt - 4'h1;
        end
    end
    assign ras_done = (ras_cnt == 4'h0) && !st.ras_n;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_st   = st;
        tmr_load  = 1'b0;
        tmr_count = '0;
        next_st.ready  = 1'b0;
        next_st.rvalid = 1'b0;
        // refresh pacing keeps every row visited inside the period
        if (st.ref_tmr == '0)
        begin
            next_st.ref_tmr  = TMR_W'(REF_PERIOD - 1);
            next_st.ref_pend = 1'b1;
        end
        else
        begin
            next_st.ref_tmr = st.ref_tmr - 1'b1;
        end
        case (st.fsm)
            EDOC_PWRUP:
            begin
                // the pause is loaded on the first clock after reset
                if (!pw_loaded)
                begin
                    tmr_load  = 1'b1;
                    tmr_count = TMR_W'(PWRUP_WAIT);
                end
                else if (tmr_done)
                begin
                    next_st.fsm = EDOC_CREF_SETUP;
                end
            end
            EDOC_IDLE:
            begin
                if (st.ref_pend || !st.init_done)
                begin
                    next_st.fsm = EDOC_CREF_SETUP;
                end
                else if (st.row_open && st.last)
                begin
                    // close first, so a waiting request cannot keep the row open
                    next_st.fsm = EDOC_CLOSE;
                end
                else if (req_valid_i)
                begin
                    next_st.ready = 1'b1;
                    next_st.wr    = req_write_i;
                    next_st.lanes = req_lanes_i;
                    next_st.last  = req_last_i;
                    next_st.wdata = req_wdata_i;
                    if (st.row_open && req_addr_i[17:9] == st.open_row)
                    begin
                        // same row: straight to a new column
                        next_st.addr = req_addr_i[8:0];
                        next_st.fsm  = EDOC_COL_LO;
                    end
                    else if (st.row_open)
                    begin
                        next_st.fsm = EDOC_CLOSE;
                        next_st.ready = 1'b0;
                    end
                    else
                    begin
                        // row half first, row strobe latches it
                        next_st.addr     = req_addr_i[17:9];
                        next_st.open_row = req_addr_i[17:9];
                        next_st.ras_n    = 1'b0;
                        next_st.row_open = 1'b1;
                        next_st.ready    = 1'b0;
                        next_st.fsm      = EDOC_ROW;
                        tmr_load  = 1'b1;
                        tmr_count = TMR_W'(RCD_CYC);
                    end
                end
            end
            EDOC_ROW:
            begin
                if (tmr_done)
                begin
                    next_st.addr  = req_addr_i[8:0];  // column half second
                    next_st.ready = 1'b1;
                    next_st.wr    = req_write_i;
                    next_st.lanes = req_lanes_i;
                    next_st.last  = req_last_i;
                    next_st.wdata = req_wdata_i;
                    next_st.fsm   = EDOC_COL_LO;
                end
            end
            EDOC_COL_LO:
            begin
                // data and write enable set on the same edge that the strobes fall
                next_st.we_n    = !st.wr;
                next_st.oe_n    = st.wr;
                next_st.dq      = st.wdata;
                next_st.dq_oe_n = !st.wr;
                next_st.cas_n   = ~st.lanes;
                next_st.fsm     = EDOC_COL_HI;
                tmr_load  = 1'b1;
                tmr_count = TMR_W'(CAS_CYC + 2);
            end
            EDOC_COL_HI:
            begin
                if (tmr_done)
                begin
                    // held output: sample after strobe rises is fine
                    next_st.rvalid  = !st.wr;
                    next_st.rdata   = dq_s;
                    next_st.cas_n   = 2'h3;
                    next_st.we_n    = 1'b1;
                    next_st.dq_oe_n = 1'b1;
                    next_st.fsm     = EDOC_IDLE;
                    if (!st.wr && st.ref_pend && ras_done && st.lanes != 2'h0)
                    begin
                        // hidden refresh: column stays low, row pulses high
                        next_st.cas_n    = st.cas_n;
                        next_st.ras_n    = 1'b1;
                        next_st.row_open = 1'b0;
                        next_st.last     = 1'b0;
                        next_st.fsm      = EDOC_CREF_RAS;
                        tmr_load  = 1'b1;
                        tmr_count = TMR_W'(RP_CYC);
                    end
                end
            end
            EDOC_CLOSE:
            begin
                if (ras_done)
                begin
                    next_st.ras_n    = 1'b1;  // end cycle all high
                    next_st.oe_n     = 1'b1;
                    next_st.row_open = 1'b0;
                    next_st.last     = 1'b0;
                    next_st.fsm      = EDOC_PRECH;
                    tmr_load  = 1'b1;
                    tmr_count = TMR_W'(RP_CYC);
                end
            end
            EDOC_CREF_SETUP:
            begin
                if (st.row_open)
                begin
                    next_st.fsm = EDOC_CLOSE;
                end
                else
                begin
                    // column low before row falls, address ignored
                    next_st.cas_n   = 2'h0;
                    next_st.dq_oe_n = 1'b1;
                    next_st.fsm     = EDOC_CREF_RAS;
                    tmr_load  = 1'b1;
                    tmr_count = TMR_W'(CSR_CYC);
                end
            end
            EDOC_CREF_RAS:
            begin
                if (st.ras_n && tmr_done)
                begin
                    next_st.ras_n = 1'b0;
                end
                else if (ras_done)
                begin
                    next_st.ras_n    = 1'b1;
                    next_st.cas_n    = 2'h3;
                    next_st.ref_pend = 1'b0;
                    if (!st.init_done)
                    begin
                        next_st.init_cnt  = st.init_cnt + 4'h1;
                        next_st.init_done = (st.init_cnt == 4'(INIT_CYCLES - 1));
                    end
                    next_st.fsm = EDOC_PRECH;
                    tmr_load  = 1'b1;
                    tmr_count = TMR_W'(RP_CYC);
                end
            end
            EDOC_PRECH:
            begin
                if (tmr_done)
                begin
                    next_st.fsm = EDOC_IDLE;
                end
            end
            default:
            begin
                next_st.fsm = EDOC_IDLE;
            end
        endcase
        if (st.ref_tmr == '0)
        begin
            next_st.ref_pend = 1'b1;  // a new tick outranks a finishing refresh
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st         <= '0;
            st.fsm     <= EDOC_PWRUP;
            st.ras_n   <= 1'b1;
            st.cas_n   <= 2'h3;
            st.we_n    <= 1'b1;
            st.oe_n    <= 1'b1;
            st.dq_oe_n <= 1'b1;
            st.ref_tmr <= TMR_W'(REF_PERIOD - 1);
        end
        else
        begin
            st <= next_st;
        end
    end

    // power-up pause is loaded once at reset release
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pw_loaded <= 1'b0;
        end
        else
        begin
            pw_loaded <= 1'b1;
        end
    end

    assign req_ready_o                 = st.ready;
    assign rd_valid_o                  = st.rvalid;
    assign rd_data_o                   = st.rdata;
    assign init_done_o                 = st.init_done;
    assign muxed_address_o             = st.addr;
    assign row_strobe_n_o              = st.ras_n;
    assign low_lane_column_strobe_n_o  = st.cas_n[0];
    assign high_lane_column_strobe_n_o = st.cas_n[1];
    assign write_enable_n_o            = st.we_n;
    assign output_enable_n_o           = st.oe_n;
    assign data_lines_o                = st.dq;
    assign data_lines_oe_n_o           = st.dq_oe_n;

    ////////////////////////////////////////////////////////////////////////////
    property p_cref_order;
        @(posedge sys_clk_i) disable iff (!rst_n)
        $fell(st.ras_n) && st.fsm == EDOC_CREF_RAS |-> st.cas_n != 2'h3;
    endproperty
    a_cref_order: assert property (p_cref_order) else $error("row fell without column");

    property p_cref_float;
        @(posedge sys_clk_i) disable iff (!rst_n)
        st.fsm == EDOC_CREF_RAS |-> st.dq_oe_n;
    endproperty
    a_cref_float: assert property (p_cref_float) else $error("driving in refresh");

    property p_ras_min;
        @(posedge sys_clk_i) disable iff (!rst_n)
        $fell(st.ras_n) |-> !st.ras_n [*3];
    endproperty
    a_ras_min: assert property (p_ras_min) else $error("row pulse short");

    property p_prech;
        @(posedge sys_clk_i) disable iff (!rst_n)
        $rose(st.ras_n) |-> st.ras_n [*2];
    endproperty
    a_prech: assert property (p_prech) else $error("precharge short");

    sequence s_wr_setup;
        !st.we_n && !st.dq_oe_n;
    endsequence
    property p_wr_data;
        @(posedge sys_clk_i) disable iff (!rst_n)
        $fell(st.cas_n[0]) && st.wr && st.fsm == EDOC_COL_HI |-> s_wr_setup;
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data late");

    property p_idle_float;
        @(posedge sys_clk_i) disable iff (!rst_n)
        st.ras_n && st.cas_n == 2'h3 |-> st.dq_oe_n;
    endproperty
    a_idle_float: assert property (p_idle_float) else $error("standby driving");

    property p_rd_oe;
        @(posedge sys_clk_i) disable iff (!rst_n)
        st.fsm == EDOC_COL_HI && !st.wr |-> st.we_n && !st.oe_n;
    endproperty
    a_rd_oe: assert property (p_rd_oe) else $error("read control wrong");

    property p_lanes;
        @(posedge sys_clk_i) disable iff (!rst_n)
        st.fsm == EDOC_COL_HI && st.cas_n != 2'h3 |-> st.cas_n == ~st.lanes;
    endproperty
    a_lanes: assert property (p_lanes) else $error("lane strobes wrong");

    property p_init;
        @(posedge sys_clk_i) disable iff (!rst_n)
        st.ready |-> st.init_done;
    endproperty
    a_init: assert property (p_init) else $error("access before init");

endmodule : edoc_ctrl

// ===== core/edoc_pkg.sv
// constants for the page-mode dram access controller
package edoc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned ADDR_W        = 9;
    localparam int unsigned CELL_ADDR_W   = 18;
    localparam int unsigned DATA_W        = 16;
    localparam int unsigned ROWS          = 512;
    // timing for the slowest grade, in ns except where the name says ms or us, and derived cycle counts
    localparam int unsigned T_RAS_NS      = 60;
    localparam int unsigned T_RP_NS       = 40;
    localparam int unsigned T_RCD_NS      = 20;
    localparam int unsigned T_CAS_NS      = 10;
    localparam int unsigned T_CP_NS       = 10;
    localparam int unsigned T_CSR_NS      = 10;
    localparam int unsigned T_REF_MS      = 8;
    localparam int unsigned T_PWRUP_US    = 200;
    localparam int unsigned INIT_CYCLES   = 8;
    localparam int unsigned RAS_CYC  = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RP_CYC   = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RCD_CYC  = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CAS_CYC  = (T_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CP_CYC   = (T_CP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CSR_CYC  = (T_CSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // longest refresh spacing rounds down
    localparam int unsigned REF_PERIOD_DEF = (T_REF_MS * 1000000) / (ROWS * CLK_PERIOD_NS);
    localparam int unsigned PWRUP_DEF = (T_PWRUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TMR_W = 16;

    typedef enum logic [3:0] {
        EDOC_PWRUP,
        EDOC_IDLE,
        EDOC_ROW,
        EDOC_COL_LO,
        EDOC_COL_HI,
        EDOC_CREF_SETUP,
        EDOC_CREF_RAS,
        EDOC_CLOSE,
        EDOC_PRECH
    } edoc_state_t;
endpackage : edoc_pkg

// ===== core/edoc_timer.sv
// down-counting delay timer used for strobe timing
`timescale 1ns/100ps
module edoc_timer
    import edoc_pkg::*;
(
    input  wire logic              sys_clk_i,  // system clock
    input  wire logic              rst_n_i,    // synchronised reset
    input  wire logic              load_i,     // load a new count
    input  wire logic [TMR_W-1:0]  count_i,    // cycles to wait
    output logic                   done_o      // count has run out
);
    import edoc_pkg::*;

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
    } edoc_tmr_st_t;

    edoc_tmr_st_t st;
    edoc_tmr_st_t next_st;

    always_comb
    begin
        next_st = st;
        if (load_i)
        begin
            next_st.cnt = count_i;
        end
        else if (st.cnt != '0)
        begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // no path from load_i: the caller decides loads from done_o
    assign done_o = (st.cnt == '0);
endmodule : edoc_timer

// ===== tb/edoc_dram_model.sv
// behavioural page-mode dram on the far side of the controller
`timescale 1ns/100ps
module edoc_dram_model (
    input  wire logic [8:0]  addr_i,       // muxed address
    input  wire logic        ras_n_i,      // row strobe
    input  wire logic        lo_strb_n_i,  // low lane strobe
    input  wire logic        hi_strb_n_i,  // high lane strobe
    input  wire logic        we_n_i,       // write enable
    input  wire logic        oe_n_i,       // output enable
    input  wire logic [15:0] d_i,          // wire level
    output logic [15:0]      q_o,          // device side of the wire
    output logic [15:0]      ras_cnt_o,    // row strobe cycles
    output logic [15:0]      cref_cnt_o    // counter refreshes
);
    logic [15:0] mem [0:262143];
    logic [8:0]  row  = 9'h000;
    logic [8:0]  col  = 9'h000;
    logic        cref = 1'b0;
    logic [1:0]  lane = 2'b00;
    logic [15:0] dout = 16'h0000;
    wire         cas_n = lo_strb_n_i & hi_strb_n_i;
    wire         rd_on = !oe_n_i && we_n_i;
    initial ras_cnt_o = 16'h0000;
    initial cref_cnt_o = 16'h0000;
    ////////////////////////////////////////////////////////////////////////
    task automatic store_lanes;
        lane = 2'b00;
        if (!lo_strb_n_i) mem[{row, col}][7:0] = d_i[7:0];
        if (!hi_strb_n_i) mem[{row, col}][15:8] = d_i[15:8];
    endtask : store_lanes
    // pins launched on one clock edge settle in any order: look 1 ns later
    // the refresh row counter is not modelled: addresses are ignored
    always @(negedge ras_n_i)
    begin
        #1;
        ras_cnt_o = ras_cnt_o + 16'h1;
        cref = !cas_n;
        if (cref)
            cref_cnt_o = cref_cnt_o + 16'h1;
        else
        begin
            row  = addr_i;
            lane = 2'b00;   // a held column strobe keeps old data
        end
    end
    always @(posedge ras_n_i or posedge cas_n)
        if (ras_n_i && cas_n) lane = 2'b00;
    always @(negedge cas_n)
    begin
        #1;
        if (!ras_n_i && !cref)
        begin
            col = addr_i;
            if (we_n_i)
            begin
                lane = {!hi_strb_n_i, !lo_strb_n_i};
                dout = mem[{row, col}];               // held past rise
            end
            else
                store_lanes();
        end
    end
    always @(negedge we_n_i)
    begin
        #1;
        if (!cas_n && !ras_n_i && !cref) store_lanes();
    end
    // released lanes show the inverse so a stale value cannot pass
    assign q_o[7:0]  = (rd_on && lane[0]) ? dout[7:0] : ~dout[7:0];
    assign q_o[15:8] = (rd_on && lane[1]) ? dout[15:8] : ~dout[15:8];
endmodule : edoc_dram_model

// ===== tb/testbench.sv
// self-checking bench for the edo dram controller
`timescale 1ns/100ps
module testbench;
    import edoc_pkg::*;
    localparam int unsigned REF_P = 200;
    localparam int unsigned PWR_W = 20;
    localparam logic [8:0] COLS [6] = '{9'h000, 9'h1ff, 9'h055, 9'h0aa, 9'h100, 9'h0ff};
    localparam logic [8:0] ROW = 9'h1a5;
    logic        sys_clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        req_valid_i = 1'b0;
    logic        req_write_i = 1'b0;
    logic        req_last_i = 1'b0;
    logic [17:0] req_addr_i = 18'h00000;
    logic [1:0]  req_lanes_i = 2'b11;
    logic [15:0] req_wdata_i = 16'h0000;
    logic        req_ready_o, rd_valid_o, init_done_o, ras_n, lo_strb_n, hi_strb_n;
    logic        we_n, oe_n, dq_oe_n;
    logic [15:0] rd_data_o, dq_o, mq, ras_cnt, cref_cnt, c0;
    logic [8:0]  addr;
    wire  [15:0] dq = dq_oe_n ? mq : dq_o;
    int          err_count = 0;
    int          check_count = 0;
    int          n, i;
    logic [31:0] seed = 32'h6ecd;
    logic [31:0] exp_q [$];
    logic [31:0] e;
    logic [15:0] shadow [logic [17:0]];
    logic [17:0] a;
    always #10 sys_clk_i = ~sys_clk_i;
    ////////////////////////////////////////////////////////////////////////
    edoc_ctrl #(.REF_PERIOD(REF_P), .PWRUP_WAIT(PWR_W)) edoc_ctrl_inst (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
        .req_write_i(req_write_i), .req_last_i(req_last_i), .req_addr_i(req_addr_i),
        .req_lanes_i(req_lanes_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .init_done_o(init_done_o),
        .muxed_address_o(addr), .row_strobe_n_o(ras_n), .low_lane_column_strobe_n_o(lo_strb_n),
        .high_lane_column_strobe_n_o(hi_strb_n), .write_enable_n_o(we_n),
        .output_enable_n_o(oe_n), .data_lines_o(dq_o), .data_lines_oe_n_o(dq_oe_n),
        .data_lines_i(dq));
    edoc_dram_model edoc_dram_model_inst (
        .addr_i(addr), .ras_n_i(ras_n), .lo_strb_n_i(lo_strb_n), .hi_strb_n_i(hi_strb_n),
        .we_n_i(we_n), .oe_n_i(oe_n), .d_i(dq), .q_o(mq), .ras_cnt_o(ras_cnt),
        .cref_cnt_o(cref_cnt));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic results;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    // one request; the expected read word is noted for the monitor
    task automatic acc(input logic w, input logic [17:0] ad, input logic [1:0] ln,
                       input logic last);
        logic [15:0] d;
        logic [15:0] m;
        int          k;
        seed = lfsr(seed);
        d = seed[15:0];
        m = {{8{ln[1]}}, {8{ln[0]}}};
        req_valid_i <= 1'b1;
        req_write_i <= w;
        req_addr_i  <= ad;
        req_lanes_i <= ln;
        req_last_i  <= last;
        req_wdata_i <= d;
        k = 0;
        do
        begin
            @(posedge sys_clk_i);
            k++;
        end
        while (req_ready_o !== 1'b1 && k < 300);
        if (k >= 300)
        begin
            err_count++;
            results();
        end
        if (w)
            shadow[ad] = (shadow[ad] & ~m) | (d & m);
        else
            exp_q.push_back({m, shadow[ad] & m});
        req_valid_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : acc
    always @(posedge sys_clk_i)
        if (rd_valid_o === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("rd_valid_unexpected", 16'h0001, 16'h0000);
            else
            begin
                e = exp_q.pop_front();
                check("rd_data", rd_data_o & e[31:16], e[15:0]);
            end
        end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        for (n = 0; n < 5000 && ras_n !== 1'b0; n++) @(posedge sys_clk_i);
        check("powerup_wait", 16'(n >= PWR_W && n < 5000), 16'h0001);
        for (n = 0; n < 5000 && init_done_o !== 1'b1; n++) @(posedge sys_clk_i);
        check("init_done", 16'(init_done_o), 16'h0001);
        check("init_cycles", 16'(ras_cnt >= INIT_CYCLES), 16'h0001);
        for (i = 0; i < 6; i++) acc(1'b1, {ROW, COLS[i]}, 2'b11, i == 5);
        acc(1'b1, {ROW, COLS[0]}, 2'b01, 1'b0);
        acc(1'b1, {ROW, COLS[1]}, 2'b10, 1'b0);
        for (i = 0; i < 6; i++)
        begin
            acc(1'b0, {ROW, COLS[i]}, 2'b11, 1'b0);
            if (i == 2) acc(1'b1, {ROW, COLS[3]}, 2'b11, 1'b0);
        end
        acc(1'b0, {ROW, COLS[0]}, 2'b01, 1'b0);
        acc(1'b0, {ROW, COLS[1]}, 2'b10, 1'b1);
        acc(1'b1, {9'h002, 9'h033}, 2'b11, 1'b0);
        acc(1'b0, {ROW, COLS[3]}, 2'b11, 1'b0);
        acc(1'b0, {9'h002, 9'h033}, 2'b11, 1'b1);
        for (i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            a = seed[17:0];
            acc(1'b1, a, 2'b11, 1'b0);
            acc(1'b0, a, 2'b11, i[0]);
        end
        c0 = cref_cnt;
        repeat (3 * REF_P) @(posedge sys_clk_i);
        check("refresh_count", 16'((cref_cnt - c0) >= 16'h2), 16'h0001);
        // a page burst longer than the refresh spacing meets a hidden refresh
        for (i = 0; i < 40; i++) acc(1'b0, {ROW, COLS[i % 6]}, 2'b11, i == 39);
        for (n = 0; n < 100 && exp_q.size() > 0; n++) @(posedge sys_clk_i);
        check("pending_reads", 16'(exp_q.size()), 16'h0000);
        results();
    end
endmodule : testbench
